// *** bench/ptic_interconnect_chk.sv ***
// Purpose: Port-level checks of the trigger interconnect.
// Assumes: Select words change only through the register port.
// Notes: Shadow copies of the select words follow the block's writes.
`timescale 1ns/10ps
module ptic_interconnect_chk (
    input wire logic clk_in, // Bus clock.
    input wire logic reset_in, // Synchronous reset.
    input wire logic [7:0] addr_in, // Register address.
    input wire logic [31:0] wdata_in, // Write data.
    input wire logic wr_in, // Write strobe.
    input wire logic timer1_chan0_flag_in, // Timer 1 channel 0 flag.
    input wire logic periodic_chan0_flag_in, // Periodic flag 0.
    input wire logic periodic_chan1_flag_in, // Periodic flag 1.
    input wire logic low_power_timer_trigger_in, // Low power trigger.
    input wire logic [2:0][15:0] timer_count_in, // Timer counts.
    input wire logic [1:0] port_tx_in, // Port transmit levels.
    input wire logic [1:0] timer_chan0_out_in, // Channel 0 outputs.
    input wire logic conv_trigger_a_out, // Trigger A.
    input wire logic conv_trigger_b_out, // Trigger B.
    input wire logic [2:0] timer_trigger_out, // Timer triggers.
    input wire logic [2:0][15:0] timer_timebase_out, // Timebases.
    input wire logic [1:0] port_tx_out, // Transmit pins.
    input wire logic comparator_trigger_out, // Comparator trigger.
    input wire logic dac_trigger_out, // DAC advance.
    input wire logic [1:0] dma_trigger_out // DMA triggers.
);
    import ptic_pkg::*;
    logic [31:0] sh_q [8];
    // Select words seen through the shadows.
    wire logic [31:0] conv = sh_q[0];
    wire logic [31:0] ser = sh_q[2];
    wire logic [31:0] tcfg = sh_q[3];
    wire logic [31:0] misc = sh_q[6];
    wire logic map_ok = addr_in[7:5] == 3'h0 && addr_in[1:0] == 2'h0;
    // Shadows follow writes on the same edge as the block.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < 8; i++) sh_q[i] <= '0;
        end else if (wr_in && map_ok) begin
            sh_q[addr_in[4:2]] <= wdata_in;
        end
    end
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    a_conv_a_default: assert property (!conv[CONV_ALT_BIT] &&
        $rose(timer1_chan0_flag_in) |=> conv_trigger_a_out)
        else $error("paired trigger A missed");
    a_pretrig_to_b: assert property (conv[CONV_ALT_BIT] &&
        conv[CONV_PRE_BIT] && conv[11:8] == SRC_PER_CH0 &&
        $rose(periodic_chan0_flag_in) |=>
        conv_trigger_b_out && !conv_trigger_a_out)
        else $error("alternate source did not reach trigger B");
    a_pulse_single: assert property (conv_trigger_a_out |=>
        !conv_trigger_a_out) else $error("trigger A wider than one cycle");
    a_timer_select: assert property (tcfg[3:0] == SRC_PER_CH1 &&
        $rose(periodic_chan1_flag_in) |=> timer_trigger_out[0])
        else $error("timer 0 trigger missed");
    a_timebase_shared: assert property (!$past(reset_in) &&
        $past(tcfg[GTB_BIT]) |->
        timer_timebase_out[0] == $past(timer_count_in[1]))
        else $error("timer 0 not on the shared timebase");
    a_tx_modulate: assert property (!$past(reset_in) &&
        $past(ser[3:2]) == TX_MOD_TMR1 |->
        port_tx_out[0] == $past(port_tx_in[0] & timer_chan0_out_in[0]))
        else $error("port 0 transmit not modulated");
    a_cmp_trig_gate: assert property (comparator_trigger_out |->
        $past(misc[CMP_MODE_BIT] && low_power_timer_trigger_in))
        else $error("comparator trigger without cause");
    a_dac_advance: assert property (misc[DAC_SEL_BIT] &&
        $rose(periodic_chan0_flag_in) |=> dac_trigger_out)
        else $error("DAC advance missed");
    a_dma_chan0: assert property (misc[DMA_EN_LSB] &&
        $rose(periodic_chan0_flag_in) |=> dma_trigger_out[0])
        else $error("DMA channel 0 trigger missed");
endmodule : ptic_interconnect_chk

bind ptic_interconnect ptic_interconnect_chk u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in),
    .timer1_chan0_flag_in(timer1_chan0_flag_in),
    .periodic_chan0_flag_in(periodic_chan0_flag_in),
    .periodic_chan1_flag_in(periodic_chan1_flag_in),
    .low_power_timer_trigger_in(low_power_timer_trigger_in),
    .timer_count_in(timer_count_in), .port_tx_in(port_tx_in),
    .timer_chan0_out_in(timer_chan0_out_in),
    .conv_trigger_a_out(conv_trigger_a_out),
    .conv_trigger_b_out(conv_trigger_b_out),
    .timer_trigger_out(timer_trigger_out),
    .timer_timebase_out(timer_timebase_out), .port_tx_out(port_tx_out),
    .comparator_trigger_out(comparator_trigger_out),
    .dac_trigger_out(dac_trigger_out), .dma_trigger_out(dma_trigger_out)
);

// *** bench/ptic_interconnect_tb_top.sv ***
// Purpose: Self-checking bench for the trigger interconnect.
// Assumes: The model pulses each event level for two cycles.
// Notes: Rows fire one source; hand tests cover levels and reset.
`timescale 1ns/10ps
module ptic_interconnect_tb_top;
    import ptic_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [31:0] data;
        int src;
        logic [8:0] exp;
    } ptic_row_type;
    logic clk_in, reset_in, wr_in, rd_in, cmp_lvl, cmp_in;
    logic conv_a, conv_b, alt0, cmp_trig, dac;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out, rd_val;
    logic [11:0] fire, lvl;
    logic [2:0][15:0] count, timebase;
    logic [1:0] cap_pin, rx_pin, tx_in, ch0, cap_out, rx_out, tx_out, dma;
    logic [2:0] ttrig;
    logic [8:0] seen;
    ptic_row_type rows [29];
    int n_fail, tests_run, highs;
    wire logic [8:0] pulses = {conv_a, conv_b, ttrig, cmp_trig, dac, dma};
    assign cmp_in = lvl[1] | cmp_lvl;
    ptic_interconnect DUT (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .timer1_chan0_flag_in(lvl[10]),
        .timer1_chan1_flag_in(lvl[11]), .counter_overflow_flag_in(lvl[6:4]),
        .periodic_chan0_flag_in(lvl[2]), .periodic_chan1_flag_in(lvl[3]),
        .rtc_alarm_in(lvl[7]), .rtc_seconds_in(lvl[8]),
        .low_power_timer_trigger_in(lvl[9]),
        .external_trigger_pin_in(lvl[0]), .comparator_output_in(cmp_in),
        .timer_count_in(count), .timer_capture_pin_in(cap_pin),
        .port_rx_pin_in(rx_pin), .port_tx_in(tx_in),
        .timer_chan0_out_in(ch0), .conv_trigger_a_out(conv_a),
        .conv_trigger_b_out(conv_b), .timer_trigger_out(ttrig),
        .timer_timebase_out(timebase), .pulse_counter_alt_input0_out(alt0),
        .timer_capture_out(cap_out), .port_rx_out(rx_out),
        .port_tx_out(tx_out), .comparator_trigger_out(cmp_trig),
        .dac_trigger_out(dac), .dma_trigger_out(dma)
    );
    ptic_periph_model u_model (.clk_in(clk_in), .reset_in(reset_in),
        .fire_in(fire), .level_out(lvl), .count_out(count));
    // Free running bus clock.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One strobe cycle, then a spare edge so strobes never toggle twice.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1 rd_val = rdata_out;
        @(posedge clk_in);
    endtask : bus
    // Fire one source and gather every pulse output for eight cycles.
    task automatic fire_watch(input int src);
        seen = '0;
        highs = 0;
        fire[src] <= 1'b1;
        @(posedge clk_in);
        fire <= '0;
        repeat (8) begin
            #1 seen |= pulses;
            highs += $countones(pulses);
            @(posedge clk_in);
        end
    endtask : fire_watch
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // Watchdog: a hang counts as a mismatch.
    initial begin
        #500000 n_fail++;
        results();
    end
    // Main sequence: event rows, then levels, registers and reset.
    initial begin
        reset_in = 1'b1;
        {wr_in, rd_in, cmp_lvl, addr_in, wdata_in, fire} = '0;
        {cap_pin, rx_pin, tx_in, ch0} = 8'h00;
        for (int c = 0; c < 10; c++) begin
            rows[c] = '{OFS_CONV_OPT, 32'(c << 8) | 32'(!c[0]) << 1 | 32'h1,
                c, c[0] ? 9'h100 : 9'h080};
            rows[10 + c] = '{OFS_TMR0_CFG + 8'(4 * (c % 3)), 32'(c), c,
                9'h010 << (c % 3)};
        end
        rows[20] = '{OFS_CONV_OPT, 32'h0, 10, 9'h100};
        rows[21] = '{OFS_CONV_OPT, 32'h0, 11, 9'h080};
        rows[22] = '{OFS_CONV_OPT, 32'hf01, 10, 9'h000};
        rows[23] = '{OFS_CONV_OPT, 32'hf01, 2, 9'h000};
        rows[24] = '{OFS_MISC, 32'h1, 9, 9'h008};
        rows[25] = '{OFS_MISC, 32'h0, 9, 9'h000};
        rows[26] = '{OFS_MISC, 32'h2, 2, 9'h004};
        rows[27] = '{OFS_MISC, 32'hc, 2, 9'h001};
        rows[28] = '{OFS_MISC, 32'hc, 3, 9'h002};
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        foreach (rows[i]) begin
            bus(1'b1, OFS_CONV_OPT, 32'h0);
            bus(1'b1, OFS_MISC, 32'h0);
            for (int t = 0; t < 3; t++) bus(1'b1, 8'h0c + 8'(4 * t), 32'hf);
            bus(1'b1, rows[i].addr, rows[i].data);
            fire_watch(rows[i].src);
            check("row pulses", 32'(rows[i].exp), 32'(seen));
            check("row width", $countones(rows[i].exp), highs);
            if (rows[i].src == 10)
                repeat (PAIR_GAP_CYC) @(posedge clk_in);
        end
        $display("event rows done");
        bus(1'b1, OFS_TMR_SRC, 32'h3);
        bus(1'b1, OFS_SER_SRC, 32'h3);
        cmp_lvl <= 1'b1;
        repeat (5) @(posedge clk_in);
        #1 check("alt input 0", 32'h1, 32'(alt0));
        check("capture all", 32'h3, 32'(cap_out));
        check("receive all", 32'h3, 32'(rx_out));
        @(posedge clk_in);
        bus(1'b1, OFS_TMR_SRC, 32'h1);
        bus(1'b1, OFS_SER_SRC, 32'h2);
        cmp_lvl <= 1'b0;
        {cap_pin, rx_pin} <= 4'hf;
        repeat (5) @(posedge clk_in);
        #1 check("capture mix", 32'h2, 32'(cap_out));
        check("receive mix", 32'h1, 32'(rx_out));
        $display("level routes done");
        @(posedge clk_in);
        bus(1'b1, OFS_SER_SRC, 32'h24);
        bus(1'b1, OFS_TMR0_CFG, 32'h1f);
        tx_in <= 2'b11;
        ch0 <= 2'b01;
        repeat (2) @(posedge clk_in);
        #1 check("transmit", 32'h1, 32'(tx_out));
        check("timebase", 32'(count[1] - 16'h2), 32'(timebase[0]));
        @(posedge clk_in);
        bus(1'b1, OFS_CONV_OPT, 32'h903);
        bus(1'b0, OFS_CONV_OPT, 32'h0);
        check("conv readback", 32'h903, rd_val);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped read", 32'h0, rd_val);
        $display("register and modulation done");
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1 check("reset outputs", 32'h0, 32'({pulses, tx_out, alt0}));
        @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        bus(1'b0, OFS_CONV_OPT, 32'h0);
        check("conv after reset", 32'h0, rd_val);
        fire_watch(10);
        check("default A", 32'h100, 32'(seen));
        $display("reset test done");
        results();
    end
endmodule : ptic_interconnect_tb_top

// *** bench/ptic_periph_model.sv ***
// Purpose: Peripheral side model making event levels and timer counts.
// Assumes: Levels change just after the rising clock edge.
// Notes: A fired event stays high two cycles, then falls.
`timescale 1ns/10ps
module ptic_periph_model (
    input wire logic clk_in, // Bus clock.
    input wire logic reset_in, // Synchronous reset.
    input wire logic [11:0] fire_in, // One-cycle event requests.
    output logic [11:0] level_out, // Event levels by source code.
    output logic [2:0][15:0] count_out // Free running timer counts.
);
    logic [11:0] hold_q;
    // Levels fall after two cycles, so each event is one clean edge.
    // Counts step at least once a bus cycle, never slower.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            level_out <= 12'h000;
            hold_q <= 12'h000;
            count_out <= '0;
        end else begin
            level_out <= fire_in | hold_q;
            hold_q <= fire_in;
            for (int i = 0; i < 3; i++)
                count_out[i] <= count_out[i] + 16'(i + 1);
        end
    end
endmodule : ptic_periph_model

// *** rtl/ptic_interconnect.sv ***
// Purpose: Routes peripheral events and levels between on-chip blocks.
// Assumes: All peripheral flags are levels on clk_in; pins are async.
// Notes: Every output is registered; flag routes add one cycle of latency, synchronised pin routes three.
//
// Overview of operation
// - Alternate off: timer 1 channel 0 and 1 flags fire triggers A and B.
// - With alternate on, a 4-bit source field picks one trigger source.
// - The pretrigger select sends the alternate source to trigger A or B.
// - The comparator output is offered as pulse counter alternate input 0.
// - Timers 1 and 2 each may take the comparator as channel 0 capture.
// - Each serial receive input may take the comparator by its own select.
// - The low power timer trigger fires the comparator in trigger mode.
// - Each timer's 4-bit select picks its trigger from the shared sources.
// - A timer with global timebase enabled runs from timer 1's timebase.
// - Each transmit line may be modulated by timer 1 or 2 channel 0.
// - The periodic channel 0 flag advances the DAC buffer when selected.
// - Periodic flags 0 and 1 trigger DMA channels 0 and 1 when enabled.
`timescale 1ns/10ps

module ptic_interconnect (
    input wire logic clk_in, // Bus clock.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic [ptic_pkg::ADDR_W-1:0] addr_in, // Register address.
    input wire logic [ptic_pkg::DATA_W-1:0] wdata_in, // Write data.
    input wire logic wr_in, // Write strobe.
    input wire logic rd_in, // Read strobe.
    output logic [ptic_pkg::DATA_W-1:0] rdata_out, // Read data.
    input wire logic timer1_chan0_flag_in, // Timer 1 channel 0 flag.
    input wire logic timer1_chan1_flag_in, // Timer 1 channel 1 flag.
    input wire logic [ptic_pkg::TMR_N-1:0] counter_overflow_flag_in, // Ovf.
    input wire logic periodic_chan0_flag_in, // Periodic flag 0.
    input wire logic periodic_chan1_flag_in, // Periodic flag 1.
    input wire logic rtc_alarm_in, // Real-time counter alarm.
    input wire logic rtc_seconds_in, // Real-time counter seconds.
    input wire logic low_power_timer_trigger_in, // Low power timer trigger.
    input wire logic external_trigger_pin_in, // External trigger pin.
    input wire logic comparator_output_in, // Comparator output.
    input wire logic [ptic_pkg::TMR_N-1:0][ptic_pkg::CNT_W-1:0]
        timer_count_in, // Each timer's own timebase.
    input wire logic [ptic_pkg::PORT_N-1:0] timer_capture_pin_in, // T1,T2.
    input wire logic [ptic_pkg::PORT_N-1:0] port_rx_pin_in, // Rx pins.
    input wire logic [ptic_pkg::PORT_N-1:0] port_tx_in, // Tx from ports.
    input wire logic [ptic_pkg::PORT_N-1:0] timer_chan0_out_in, // T1,T2.
    output logic conv_trigger_a_out, // Converter trigger A pulse.
    output logic conv_trigger_b_out, // Converter trigger B pulse.
    output logic [ptic_pkg::TMR_N-1:0] timer_trigger_out, // Timer triggers.
    output logic [ptic_pkg::TMR_N-1:0][ptic_pkg::CNT_W-1:0]
        timer_timebase_out, // Timebase each timer uses.
    output logic pulse_counter_alt_input0_out, // Comparator level.
    output logic [ptic_pkg::PORT_N-1:0] timer_capture_out, // T1,T2 capture.
    output logic [ptic_pkg::PORT_N-1:0] port_rx_out, // Receive inputs.
    output logic [ptic_pkg::PORT_N-1:0] port_tx_out, // Transmit pins.
    output logic comparator_trigger_out, // Comparator trigger pulse.
    output logic dac_trigger_out, // DAC buffer advance pulse.
    output logic [1:0] dma_trigger_out // DMA channel 0/1 trigger pulses.
);
    import ptic_pkg::*;

    // Synchroniser lanes: ext pin, comparator, two capture, two receive.
    localparam int SYN_N = 6;
    localparam int SY_EXT = 0;
    localparam int SY_CMP = 1;
    localparam int SY_CAP = 2;
    localparam int SY_RX = 4;

    typedef struct packed {
        logic alt_en;
        logic pre_b;
        logic [SRC_W-1:0] conv_src;
        logic [PORT_N-1:0] cap_src;
        logic [PORT_N-1:0] rx_src;
        logic [PORT_N-1:0][TX_SRC_W-1:0] tx_src;
        logic [TMR_N-1:0][SRC_W-1:0] trg_sel;
        logic [TMR_N-1:0] gtb_en;
        logic cmp_mode;
        logic dac_sel;
        logic [1:0] dma_en;
        logic [SYN_N-1:0] sync1;
        logic [SYN_N-1:0] sync2;
        logic [EVT_N-1:0] evt_prev;
        logic [DATA_W-1:0] rdata;
        logic conv_a;
        logic conv_b;
        logic [TMR_N-1:0] tmr_trg;
        logic [TMR_N-1:0][CNT_W-1:0] timebase;
        logic alt0;
        logic [PORT_N-1:0] cap;
        logic [PORT_N-1:0] rx;
        logic [PORT_N-1:0] tx;
        logic cmp_trg;
        logic dac_trg;
        logic [1:0] dma_trg;
    } ptic_state_type;

    ptic_state_type state_q;
    ptic_state_type state_d;
    logic [EVT_N-1:0] evt_level;
    logic [EVT_N-1:0] evt_pulse;

    // Picks one event by source code; codes past the last source pick none.
    function automatic logic ptic_pick(input logic [SRC_W-1:0] code,
                                       input logic [EVT_N-1:0] pulses);
        logic hit;
        hit = 1'b0;
        if (code <= SRC_LAST) begin
            hit = pulses[code];
        end
        return hit;
    endfunction : ptic_pick

    // Event levels; pins are taken from the second synchroniser stage only.
    always_comb begin
        evt_level = '0;
        evt_level[SRC_EXT_PIN] = state_q.sync2[SY_EXT];
        evt_level[SRC_COMPARATOR] = state_q.sync2[SY_CMP];
        evt_level[SRC_PER_CH0] = periodic_chan0_flag_in;
        evt_level[SRC_PER_CH1] = periodic_chan1_flag_in;
        evt_level[SRC_TMR0_OVF] = counter_overflow_flag_in[0];
        evt_level[SRC_TMR1_OVF] = counter_overflow_flag_in[1];
        evt_level[SRC_TMR2_OVF] = counter_overflow_flag_in[2];
        evt_level[SRC_RTC_ALARM] = rtc_alarm_in;
        evt_level[SRC_RTC_SECONDS] = rtc_seconds_in;
        evt_level[SRC_LP_TIMER] = low_power_timer_trigger_in;
        evt_level[EVT_T1_CH0] = timer1_chan0_flag_in;
        evt_level[EVT_T1_CH1] = timer1_chan1_flag_in;
    end

    // Rising edges only, so a flag held high fires once and not every cycle.
    assign evt_pulse = evt_level & ~state_q.evt_prev;

    // Next-state logic: register port, synchronisers and every route.
    always_comb begin
        state_d = state_q;
        state_d.sync1 = {port_rx_pin_in, timer_capture_pin_in,
                         comparator_output_in, external_trigger_pin_in};
        state_d.sync2 = state_q.sync1;
        state_d.evt_prev = evt_level;

        // Register writes; unmapped offsets are ignored.
        if (wr_in) begin
            unique case (addr_in)
                OFS_CONV_OPT: begin
                    state_d.alt_en = wdata_in[CONV_ALT_BIT];
                    state_d.pre_b = wdata_in[CONV_PRE_BIT];
                    state_d.conv_src = wdata_in[CONV_SRC_LSB +: SRC_W];
                end
                OFS_TMR_SRC: begin
                    state_d.cap_src = wdata_in[CAP_SRC_LSB +: PORT_N];
                end
                OFS_SER_SRC: begin
                    state_d.rx_src = wdata_in[RX_SRC_LSB +: PORT_N];
                    state_d.tx_src = wdata_in[TX_SRC_LSB +: 2*TX_SRC_W];
                end
                OFS_TMR0_CFG, OFS_TMR1_CFG, OFS_TMR2_CFG: begin
                    for (int t = 0; t < TMR_N; t++) begin
                        if (addr_in == OFS_TMR0_CFG + 8'(4 * t)) begin
                            state_d.trg_sel[t] =
                                wdata_in[TRG_SEL_LSB +: SRC_W];
                            state_d.gtb_en[t] = wdata_in[GTB_BIT];
                        end
                    end
                end
                OFS_MISC: begin
                    state_d.cmp_mode = wdata_in[CMP_MODE_BIT];
                    state_d.dac_sel = wdata_in[DAC_SEL_BIT];
                    state_d.dma_en = wdata_in[DMA_EN_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // Register reads; data stand one cycle later, unmapped reads zero.
        state_d.rdata = '0;
        if (rd_in) begin
            unique case (addr_in)
                OFS_CONV_OPT: begin
                    state_d.rdata[CONV_ALT_BIT] = state_q.alt_en;
                    state_d.rdata[CONV_PRE_BIT] = state_q.pre_b;
                    state_d.rdata[CONV_SRC_LSB +: SRC_W] = state_q.conv_src;
                end
                OFS_TMR_SRC: begin
                    state_d.rdata[CAP_SRC_LSB +: PORT_N] = state_q.cap_src;
                end
                OFS_SER_SRC: begin
                    state_d.rdata[RX_SRC_LSB +: PORT_N] = state_q.rx_src;
                    state_d.rdata[TX_SRC_LSB +: 2*TX_SRC_W] = state_q.tx_src;
                end
                OFS_TMR0_CFG, OFS_TMR1_CFG, OFS_TMR2_CFG: begin
                    for (int t = 0; t < TMR_N; t++) begin
                        if (addr_in == OFS_TMR0_CFG + 8'(4 * t)) begin
                            state_d.rdata[TRG_SEL_LSB +: SRC_W] =
                                state_q.trg_sel[t];
                            state_d.rdata[GTB_BIT] = state_q.gtb_en[t];
                        end
                    end
                end
                OFS_MISC: begin
                    state_d.rdata[CMP_MODE_BIT] = state_q.cmp_mode;
                    state_d.rdata[DAC_SEL_BIT] = state_q.dac_sel;
                    state_d.rdata[DMA_EN_LSB +: 2] = state_q.dma_en;
                end
                OFS_STATUS: begin
                    state_d.rdata[ST_CONV_A_BIT] = state_q.conv_a;
                    state_d.rdata[ST_CONV_B_BIT] = state_q.conv_b;
                    state_d.rdata[ST_EXT_BIT] = state_q.sync2[SY_EXT];
                    state_d.rdata[ST_CMP_BIT] = state_q.sync2[SY_CMP];
                end
                default: begin
                end
            endcase
        end

        // Converter triggers: paired timer 1 flags, or one alternate source.
        // Pair spacing in stop modes is the caller's job, not checked here.
        if (!state_q.alt_en) begin
            state_d.conv_a = evt_pulse[EVT_T1_CH0];
            state_d.conv_b = evt_pulse[EVT_T1_CH1];
        end else begin
            state_d.conv_a = !state_q.pre_b &&
                ptic_pick(state_q.conv_src, evt_pulse);
            state_d.conv_b = state_q.pre_b &&
                ptic_pick(state_q.conv_src, evt_pulse);
        end

        // Per-timer trigger select and global timebase.
        for (int t = 0; t < TMR_N; t++) begin
            state_d.tmr_trg[t] =
                ptic_pick(state_q.trg_sel[t], evt_pulse);
            state_d.timebase[t] = state_q.gtb_en[t] ?
                timer_count_in[1] : timer_count_in[t];
        end

        // Comparator level to the pulse counter's alternate input 0.
        state_d.alt0 = state_q.sync2[SY_CMP];

        // Capture, receive and transmit steering for both ports.
        for (int p = 0; p < PORT_N; p++) begin
            state_d.cap[p] = state_q.cap_src[p] ?
                state_q.sync2[SY_CMP] : state_q.sync2[SY_CAP + p];
            state_d.rx[p] = state_q.rx_src[p] ?
                state_q.sync2[SY_CMP] : state_q.sync2[SY_RX + p];
            unique case (state_q.tx_src[p])
                TX_MOD_TMR1: state_d.tx[p] =
                    port_tx_in[p] & timer_chan0_out_in[0];
                TX_MOD_TMR2: state_d.tx[p] =
                    port_tx_in[p] & timer_chan0_out_in[1];
                default: state_d.tx[p] = port_tx_in[p];
            endcase
        end

        // Periodic comparator, DAC and DMA hardware triggers.
        state_d.cmp_trg = state_q.cmp_mode &&
            evt_pulse[SRC_LP_TIMER];
        state_d.dac_trg = state_q.dac_sel &&
            evt_pulse[SRC_PER_CH0];
        state_d.dma_trg[0] = state_q.dma_en[0] &&
            evt_pulse[SRC_PER_CH0];
        state_d.dma_trg[1] = state_q.dma_en[1] &&
            evt_pulse[SRC_PER_CH1];
    end

    // State register; reset clears every option and output.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from the state register.
    assign rdata_out = state_q.rdata;
    assign conv_trigger_a_out = state_q.conv_a;
    assign conv_trigger_b_out = state_q.conv_b;
    assign timer_trigger_out = state_q.tmr_trg;
    assign timer_timebase_out = state_q.timebase;
    assign pulse_counter_alt_input0_out = state_q.alt0;
    assign timer_capture_out = state_q.cap;
    assign port_rx_out = state_q.rx;
    assign port_tx_out = state_q.tx;
    assign comparator_trigger_out = state_q.cmp_trg;
    assign dac_trigger_out = state_q.dac_trg;
    assign dma_trigger_out = state_q.dma_trg;

endmodule : ptic_interconnect

// *** rtl/ptic_pkg.sv ***
// Purpose: Shared constants for the peripheral trigger interconnect.
// Assumes: One 100 MHz bus clock; registers are 32-bit aligned words.
// Notes: Offsets are byte addresses on the plain register port.
package ptic_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONV_OPT = 8'h00;
    localparam logic [7:0] OFS_TMR_SRC = 8'h04;
    localparam logic [7:0] OFS_SER_SRC = 8'h08;
    localparam logic [7:0] OFS_TMR0_CFG = 8'h0c;
    localparam logic [7:0] OFS_TMR1_CFG = 8'h10;
    localparam logic [7:0] OFS_TMR2_CFG = 8'h14;
    localparam logic [7:0] OFS_MISC = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // Conversion trigger option fields.
    localparam int CONV_ALT_BIT = 0;
    localparam int CONV_PRE_BIT = 1;
    localparam int CONV_SRC_LSB = 8;
    localparam int SRC_W = 4;

    // Timer source fields: capture select per timer 1 and 2.
    localparam int CAP_SRC_LSB = 0;

    // Serial source fields.
    localparam int RX_SRC_LSB = 0;
    localparam int TX_SRC_LSB = 2;
    localparam int TX_SRC_W = 2;

    // Per-timer configuration fields.
    localparam int TRG_SEL_LSB = 0;
    localparam int GTB_BIT = 4;

    // Miscellaneous option fields.
    localparam int CMP_MODE_BIT = 0;
    localparam int DAC_SEL_BIT = 1;
    localparam int DMA_EN_LSB = 2;

    // Status fields.
    localparam int ST_CONV_A_BIT = 0;
    localparam int ST_CONV_B_BIT = 1;
    localparam int ST_EXT_BIT = 2;
    localparam int ST_CMP_BIT = 3;

    // Block sizes.
    localparam int TMR_N = 3;
    localparam int CNT_W = 16;
    localparam int PORT_N = 2;
    localparam int EVT_N = 12;

    // Trigger source codes shared by the converter and timer selects.
    localparam logic [3:0] SRC_EXT_PIN = 4'h0;
    localparam logic [3:0] SRC_COMPARATOR = 4'h1;
    localparam logic [3:0] SRC_PER_CH0 = 4'h2;
    localparam logic [3:0] SRC_PER_CH1 = 4'h3;
    localparam logic [3:0] SRC_TMR0_OVF = 4'h4;
    localparam logic [3:0] SRC_TMR1_OVF = 4'h5;
    localparam logic [3:0] SRC_TMR2_OVF = 4'h6;
    localparam logic [3:0] SRC_RTC_ALARM = 4'h7;
    localparam logic [3:0] SRC_RTC_SECONDS = 4'h8;
    localparam logic [3:0] SRC_LP_TIMER = 4'h9;
    localparam logic [3:0] SRC_LAST = SRC_LP_TIMER;

    // Extra event slots used only by the paired conversion triggers.
    localparam int EVT_T1_CH0 = 10;
    localparam int EVT_T1_CH1 = 11;

    // Transmit modulation codes.
    localparam logic [1:0] TX_PLAIN = 2'h0;
    localparam logic [1:0] TX_MOD_TMR1 = 2'h1;
    localparam logic [1:0] TX_MOD_TMR2 = 2'h2;

    // Least spacing of paired triggers in stop modes, kept by software.
    localparam int PAIR_GAP_US = 10;
    localparam int CLK_MHZ = 100;
    localparam int PAIR_GAP_CYC = PAIR_GAP_US * CLK_MHZ;

endpackage : ptic_pkg
